// *** verilog/ceu_pkg.sv ***
// ceu_pkg: constants and types for the comparator event control block
// assumes a single 100 MHz bus clock and an 8-bit register port
package ceu_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 2;

  // register offsets
  localparam logic [ADDR_W-1:0] STATUS_CTRL_OFS = 2'h0;
  localparam logic [ADDR_W-1:0] SYS_OPT_TWO_OFS = 2'h1;
  localparam logic [ADDR_W-1:0] PWR_CTRL_ONE_OFS = 2'h2;

  // status and control field positions
  localparam int unsigned ENABLE_BIT = 7;
  localparam int unsigned REFSEL_BIT = 6;
  localparam int unsigned FLAG_BIT = 5;
  localparam int unsigned IRQEN_BIT = 4;
  localparam int unsigned RESULT_BIT = 3;
  localparam int unsigned PINEN_BIT = 2;
  localparam int unsigned MODE_HI_BIT = 1;
  localparam int unsigned MODE_LO_BIT = 0;
  // option register field positions
  localparam int unsigned CAPROUTE_BIT = 0;
  localparam int unsigned REFBUF_BIT = 0;

  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

  typedef enum logic [1:0] {
    MODE_FALL_A = 2'h0,
    MODE_RISE   = 2'h1,
    MODE_FALL_B = 2'h2,
    MODE_BOTH   = 2'h3
  } ceu_mode_t;

  typedef struct packed {
    logic      enable;
    logic      refSel;
    logic      irqEn;
    logic      pinEn;
    ceu_mode_t mode;
  } ceu_ctrl_t;

  localparam ceu_ctrl_t CTRL_RESET = '{1'b0, 1'b0, 1'b0, 1'b0, MODE_FALL_A};

endpackage : ceu_pkg

// *** verilog/ceu_top.sv ***
// ceu_top: digital control around an analog comparator, with one register port
// assumes the analog result arrives as a raw level; powerDown resets state on stop2
// assumes the register port runs on the same clock and never waits
// assumes the analog side owns the reference buffer and the input mux levels
// Functional notes
// (RULE1) software sets the reference buffer bit before selecting the internal reference
// (RULE2) capture routing bit feeds comparator result to timer one channel zero
// (RULE3) while routed, the timer one channel zero pin is unavailable externally
// (RULE4) events selectable as rising, falling or both edges
// (RULE5) result optionally driven on the result pin under pin enable
// (RULE6) input select picks internal reference instead of noninverting pin
// (RULE7) block keeps running in wait mode when enabled
// (RULE8) event in wait with irq enable raises wake interrupt
// (RULE9) software should disable the block before wait if not a wake source
// (RULE10) block keeps comparing and detecting events in stop3
// (RULE11) in stop3 result pin is driven as in run mode
// (RULE12) stop3 event sets flag and wakes processor when enabled
// (RULE13) reset exit from stop returns all state to reset values
// (RULE14) stop2 powers block off; state after wake equals reset state
// (RULE15) in background debug mode block operates normally
// (RULE16) mode 00 and 10 falling, 01 rising, 11 either edge
// (RULE17) flag set by event, cleared only by writing one to it
// (RULE18) interrupt request when flag and irq enable both set
// (RULE19) result status bit reads present result, zero when disabled
// (RULE20) raw result passes two flip-flops before edge detection
`timescale 1ns/10ps
module ceu_top (
  input  wire logic                       sys_clk,
  input  wire logic                       sys_rst,
  input  wire logic [ceu_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [ceu_pkg::DATA_W-1:0] regWrData,
  input  wire logic                       regWrStb,
  input  wire logic                       regRdStb,
  output logic      [ceu_pkg::DATA_W-1:0] regRdData,
  input  wire logic                       compareRaw,
  input  wire logic                       powerDown,
  input  wire logic                       timer1Channel0PinIn,
  output logic                            compareResultPin,
  output logic                            compareResultPinOeN,
  output logic                            timer1Capture0,
  output logic                            timer1Channel0PinAvail,
  output logic                            compareIrqReq,
  output logic                            refSelectOut,
  output logic                            referenceBufferEnable,
  output logic                            comparatorPowerOn
);
  import ceu_pkg::*;

  // architectural state
  ceu_ctrl_t         ctrl_reg;
  ceu_ctrl_t         ctrl_next;
  logic              flag_reg;
  logic              flag_next;
  logic              capRoute_reg;
  logic              capRoute_next;
  logic              refBuf_reg;
  logic              refBuf_next;
  logic [DATA_W-1:0] rdData_reg;
  logic [DATA_W-1:0] rdData_next;

  // synchroniser and edge history
  logic              syncA_reg;
  logic              syncA_next;
  logic              syncB_reg;
  logic              syncB_next;
  logic              prev_reg;
  logic              prev_next;

  // reset, decode and write fields
  logic              blockRst;
  logic              selCtrl;
  logic              selOpt;
  logic              selPwr;
  logic              selNone;
  logic              wrCtrl;
  logic              wrOpt;
  logic              wrPwr;
  logic              wrEnableVal;
  logic              wrRefSelVal;
  logic              wrFlagVal;
  logic              flagClear;
  logic              wrIrqEnVal;
  logic              wrPinEnVal;
  logic [1:0]        wrModeBits;
  ceu_mode_t         wrModeVal;
  logic              wrCapVal;
  logic              wrRefBufVal;

  // edge detection and results
  logic              enabled;
  logic              rising;
  logic              falling;
  logic              compareEvent;
  logic              resultBit;

  // read views
  logic              viewEnable;
  logic              viewRefSel;
  logic              viewFlag;
  logic              viewIrqEn;
  logic              viewResult;
  logic              viewPinEn;
  logic [1:0]        viewMode;
  logic [DATA_W-1:0] ctrlView;
  logic [DATA_W-1:0] optView;
  logic [DATA_W-1:0] pwrView;
  logic [DATA_W-1:0] rdMux;

  // pin side levels
  logic              pinDrive;
  logic              pinLevel;
  logic              pinAvailLevel;
  logic              captureSrc;
  logic              irqLevel;
  logic              refSelLevel;
  logic              refBufLevel;
  logic              powerLevel;

  // true when the port address hits a given register offset
  function automatic logic addrHit(input logic [ADDR_W-1:0] addr,
                                   input logic [ADDR_W-1:0] ofs);
    addrHit = (addr == ofs);
  endfunction : addrHit

  // one field bit of a written byte
  function automatic logic fieldBit(input logic [DATA_W-1:0] data,
                                    input int unsigned       pos);
    fieldBit = data[pos];
  endfunction : fieldBit

  // a single-bit register as seen on the read port
  function automatic logic [DATA_W-1:0] lowBitByte(input logic b);
    lowBitByte = {{(DATA_W-1){1'b0}}, b};
  endfunction : lowBitByte

  // a change of level between two samples, seen from its new value
  function automatic logic edgeOf(input logic now, input logic was);
    edgeOf = now & ~was;
  endfunction : edgeOf

  // next value of a plain software-written bit
  function automatic logic loadOrHold(input logic load,
                                      input logic val,
                                      input logic cur);
    loadOrHold = load ? val : cur;
  endfunction : loadOrHold

  // event decode per mode; both falling encodings behave alike
  function automatic logic eventHit(input ceu_mode_t m,
                                    input logic      r,
                                    input logic      f);
    unique case (m)
      MODE_RISE: eventHit = r;
      MODE_BOTH: eventHit = r | f;
      MODE_FALL_A, MODE_FALL_B: eventHit = f;
    endcase
  endfunction : eventHit

  // stop2 power-down acts as a reset on all state but the read data; a reset leaving stop resets everything
  assign blockRst = sys_rst | powerDown; // (RULE13) (RULE14)

  // writes to an unmapped offset select nothing and are dropped
  assign selCtrl = addrHit(regAddr, STATUS_CTRL_OFS);
  assign selOpt  = addrHit(regAddr, SYS_OPT_TWO_OFS);
  assign selPwr  = addrHit(regAddr, PWR_CTRL_ONE_OFS);
  assign selNone = ~(selCtrl | selOpt | selPwr);
  assign wrCtrl  = regWrStb & selCtrl;
  assign wrOpt   = regWrStb & selOpt;
  assign wrPwr   = regWrStb & selPwr;

  // field values of the written byte
  assign wrEnableVal = fieldBit(regWrData, ENABLE_BIT);
  assign wrRefSelVal = fieldBit(regWrData, REFSEL_BIT);
  assign wrFlagVal   = fieldBit(regWrData, FLAG_BIT);
  assign flagClear   = wrCtrl & wrFlagVal;
  assign wrIrqEnVal  = fieldBit(regWrData, IRQEN_BIT);
  assign wrPinEnVal  = fieldBit(regWrData, PINEN_BIT);
  assign wrModeBits  = regWrData[MODE_HI_BIT:MODE_LO_BIT];
  assign wrModeVal   = ceu_mode_t'(wrModeBits);
  assign wrCapVal    = fieldBit(regWrData, CAPROUTE_BIT);
  assign wrRefBufVal = fieldBit(regWrData, REFBUF_BIT);

  assign enabled = ctrl_reg.enable;

  // edge detect on the second synchroniser stage only
  assign rising  = edgeOf(syncB_reg, prev_reg);
  assign falling = edgeOf(prev_reg, syncB_reg);
  // prev resets low and tracks even while disabled, so only a level high at reset exit shows a rising edge

  // no wait, stop3 or debug gating: events run whenever enabled
  assign compareEvent = enabled &                          // (RULE7) (RULE10) (RULE15)
                        eventHit(ctrl_reg.mode, rising, falling); // (RULE4) (RULE16)

  // set wins over a clear in the same cycle
  assign flag_next = compareEvent | (flag_reg & ~flagClear); // (RULE17)

  // result reads zero while the block is disabled
  assign resultBit = enabled & syncB_reg; // (RULE19)

  always_comb begin
    ctrl_next = ctrl_reg;
    if (wrCtrl) begin
      ctrl_next.enable = wrEnableVal;
      ctrl_next.refSel = wrRefSelVal;
      ctrl_next.irqEn  = wrIrqEnVal;
      ctrl_next.pinEn  = wrPinEnVal;
      ctrl_next.mode   = wrModeVal;
    end
  end

  // option bits hold unless their own offset is written
  assign capRoute_next = loadOrHold(wrOpt, wrCapVal, capRoute_reg);
  assign refBuf_next   = loadOrHold(wrPwr, wrRefBufVal, refBuf_reg);

  // two flip-flops ahead of the edge detector keep the flag glitch-free
  assign syncA_next = compareRaw; // (RULE20)
  assign syncB_next = syncA_reg;  // (RULE20)
  assign prev_next  = syncB_reg;

  // the result bit is read-only: writes never reach it
  assign viewEnable = ctrl_reg.enable;
  assign viewRefSel = ctrl_reg.refSel;
  assign viewFlag   = flag_reg;
  assign viewIrqEn  = ctrl_reg.irqEn;
  assign viewResult = resultBit;
  assign viewPinEn  = ctrl_reg.pinEn;
  assign viewMode   = ctrl_reg.mode;
  assign ctrlView = {viewEnable,
                     viewRefSel,
                     viewFlag,
                     viewIrqEn,
                     viewResult,
                     viewPinEn,
                     viewMode};
  assign optView  = lowBitByte(capRoute_reg);
  assign pwrView  = lowBitByte(refBuf_reg);
  // unmapped offsets read zero
  assign rdMux    = selNone ? ZERO_BYTE :
                    selCtrl ? ctrlView  :
                    selOpt  ? optView   : pwrView;

  // read data stand for one cycle only, zero otherwise
  assign rdData_next = regRdStb ? rdMux : ZERO_BYTE;

  // one short register process each keeps every reset path plain
  // control fields
  always_ff @(posedge sys_clk) begin
    if (blockRst) begin
      ctrl_reg <= CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // event flag
  always_ff @(posedge sys_clk) begin
    if (blockRst) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  // capture routing option
  always_ff @(posedge sys_clk) begin
    if (blockRst) begin
      capRoute_reg <= 1'b0;
    end else begin
      capRoute_reg <= capRoute_next;
    end
  end

  // reference buffer option
  always_ff @(posedge sys_clk) begin
    if (blockRst) begin
      refBuf_reg <= 1'b0;
    end else begin
      refBuf_reg <= refBuf_next;
    end
  end

  // first synchroniser stage
  always_ff @(posedge sys_clk) begin
    if (blockRst) begin
      syncA_reg <= 1'b0;
    end else begin
      syncA_reg <= syncA_next;
    end
  end

  // second synchroniser stage
  always_ff @(posedge sys_clk) begin
    if (blockRst) begin
      syncB_reg <= 1'b0;
    end else begin
      syncB_reg <= syncB_next;
    end
  end

  // previous sample for edge detection
  always_ff @(posedge sys_clk) begin
    if (blockRst) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= prev_next;
    end
  end

  // read data belong to the bus side, so power-down leaves them alone
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdData_reg <= ZERO_BYTE;
    end else begin
      rdData_reg <= rdData_next;
    end
  end

  // pin driven in run and stop3 alike
  assign pinDrive      = ctrl_reg.pinEn & enabled;  // (RULE5) (RULE11)
  assign pinLevel      = resultBit & ctrl_reg.pinEn; // (RULE5) (RULE11)
  // routing takes the timer channel away from its pin
  assign pinAvailLevel = ~capRoute_reg; // (RULE3)
  assign captureSrc    = capRoute_reg ? resultBit : timer1Channel0PinIn; // (RULE2)
  // level request, held until the flag is cleared
  assign irqLevel      = flag_reg & ctrl_reg.irqEn; // (RULE18) (RULE8) (RULE12)
  // the buffer bit is only exported; software sets it before selecting the reference
  assign refSelLevel   = ctrl_reg.refSel; // (RULE6)
  assign refBufLevel   = refBuf_reg;
  assign powerLevel    = enabled & ~powerDown;

  assign regRdData              = rdData_reg;
  assign compareResultPin       = pinLevel;
  assign compareResultPinOeN    = ~pinDrive;
  assign timer1Capture0         = captureSrc;
  assign timer1Channel0PinAvail = pinAvailLevel;
  assign compareIrqReq          = irqLevel;
  assign refSelectOut           = refSelLevel;
  assign referenceBufferEnable  = refBufLevel;
  assign comparatorPowerOn      = powerLevel;

endmodule : ceu_top

// *** tb/ceu_analog.sv ***
// ceu_analog: comparator front end, voltages in millivolts
// assumes the bench sets the noninverting input
`timescale 1ns/10ps
module ceu_analog #(
  parameter logic [15:0] REF_MV   = 16'h04B0,
  parameter logic [15:0] MINUS_MV = 16'h0320
) (
  input  wire logic [15:0] plusMv,
  input  wire logic        refSel,
  input  wire logic        bufEn,
  output logic             compareRaw
);
  // an unbuffered reference collapses to ground
  assign compareRaw = (refSel ? (bufEn ? REF_MV : 16'h0000) : plusMv) > MINUS_MV;
endmodule : ceu_analog

// *** tb/ceu_chk.sv ***
// ceu_chk: port checks for ceu_top
// assumes one clock, sync high reset
`timescale 1ns/10ps
module ceu_chk (
  input wire logic       sys_clk, sys_rst, regWrStb, regRdStb, compareRaw, powerDown,
  input wire logic       timer1Channel0PinIn, compareResultPin, compareResultPinOeN,
  input wire logic       timer1Capture0, timer1Channel0PinAvail, compareIrqReq,
  input wire logic [1:0] regAddr,
  input wire logic [7:0] regRdData
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_pin_idle: assert property (compareResultPinOeN |-> !compareResultPin)
    else $error("pin idle");
  a_pin_track: assert property (!compareResultPinOeN && $stable(compareResultPinOeN)
    |-> compareResultPin == $past(compareRaw, 2)) else $error("pin track");
  a_pin_free: assert property (timer1Channel0PinAvail
    |-> timer1Capture0 == timer1Channel0PinIn) else $error("pin free");
  a_route_cap: assert property (!timer1Channel0PinAvail && !compareResultPinOeN
    |-> timer1Capture0 == compareResultPin) else $error("route");
  a_unmapped_rd: assert property ($past(regRdStb && regAddr == 2'h3)
    |-> regRdData == 8'h00) else $error("unmapped");
  a_irq_cause: assert property ($rose(compareIrqReq) |-> $past(regWrStb)
    || $past(compareRaw, 3) != $past(compareRaw, 4)) else $error("irq cause");
  a_power_clr: assert property ($past(powerDown)
    |-> !compareIrqReq && compareResultPinOeN) else $error("power down");
  a_rst_state: assert property ($past(sys_rst) |-> timer1Channel0PinAvail
    && compareResultPinOeN && !compareIrqReq) else $error("reset state");
endmodule : ceu_chk
bind ceu_top ceu_chk chk (.*);

// *** tb/tb.sv ***
// tb: ceu_top against an analog front end model
// assumes the ceu_pkg status layout
`timescale 1ns/10ps
module tb;
  logic sys_clk = 0, sys_rst = 1, regWrStb = 0, regRdStb = 0, powerDown = 0;
  logic timer1Channel0PinIn = 0, compareRaw, compareResultPin, compareResultPinOeN;
  logic timer1Capture0, timer1Channel0PinAvail, compareIrqReq, refSelectOut;
  logic referenceBufferEnable, comparatorPowerOn;
  logic [1:0]  regAddr = 0;
  logic [7:0]  regWrData = 0, regRdData, e;
  logic [15:0] plusMv = 0;
  int errTotal = 0, nTests = 0, cyc = 0, seed = 67;
  always #5 sys_clk = ~sys_clk;
  ceu_top dut (.*);
  ceu_analog fe (.plusMv, .refSel(refSelectOut), .bufEn(referenceBufferEnable), .compareRaw);
  task automatic testDone;
    $display("checks %0d errors %0d", nTests, errTotal);
    if (errTotal == 0 && nTests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : testDone
  always @(posedge sys_clk) if (++cyc == 3000) begin
    errTotal++;
    testDone();
  end
  task automatic chk(input logic [7:0] g, x, input string s);
    nTests++;
    if (g !== x) begin
      errTotal++;
      $display("Error %s expected %h seen %h", s, x, g);
    end
  endtask : chk
  // a read compares the masked data with d
  task automatic bus(input logic w, input logic [1:0] a, input logic [7:0] d, m);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= w;
    regRdStb <= !w;
    @(posedge sys_clk) {regWrStb, regRdStb} <= 2'b00;
    @(posedge sys_clk) if (!w) chk(regRdData & m, d, "regRdData");
  endtask : bus
  initial begin
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    for (int a = 0; a < 4; a++) bus(0, 2'(a), 8'h00, 8'hFF);
    bus(1, 2'h2, 8'h01, 0);
    chk(referenceBufferEnable, 1, "refBuf");
    bus(1, 2'h1, 8'h01, 0);
    chk(timer1Channel0PinAvail, 0, "pinAvail");
    for (int m = 0; m < 4; m++) for (int v = 1; v >= 0; v--) begin
      e = {2'b00, (v[0] ? m[0] : m != 1), 1'b0, v[0], 3'h0};
      bus(1, 2'h0, 8'hB4 | 8'(m), 0);
      plusMv <= (v[0] ? 16'h0321 : 16'h0220) + 16'($random(seed) & 32'hFF);
      timer1Channel0PinIn <= 1'($random(seed));
      repeat (8) @(posedge sys_clk);
      bus(0, 2'h0, e, 8'h28);
      chk(compareIrqReq, e[5], "irq");
      chk(timer1Capture0, v[0], "capture");
      chk(compareResultPin, v[0], "resultPin");
      chk(comparatorPowerOn, 1, "powerOn");
      bus(1, 2'h0, 8'h94 | 8'(m), 0);
      bus(0, 2'h0, e & 8'h20, 8'h20);
    end
    bus(1, 2'h0, 8'hC0, 0);
    chk(refSelectOut, 1, "refSel");
    repeat (4) @(posedge sys_clk);
    bus(0, 2'h0, 8'h48, 8'h48);
    bus(1, 2'h0, 8'h40, 0);
    bus(0, 2'h0, 8'h00, 8'h08);
    bus(1, 2'h0, 8'hD4, 0);
    powerDown <= 1'b1;
    @(posedge sys_clk) powerDown <= 1'b0;
    bus(0, 2'h0, 8'h00, 8'hFF);
    chk(comparatorPowerOn, 0, "powerOn");
    chk(timer1Channel0PinAvail, 1, "pinAvail");
    testDone();
  end
endmodule : tb
